// File: common/smap_pkg.sv
// Constants and types for the sensor memory access and write-protect block
package smap_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Device addresses
	localparam logic [7:0] AUX_DEV_ADDR      = 8'ha0;
	localparam logic [7:0] MAIN_ADDR_DEFAULT = 8'ha2;

	////////////////////////////////////////////////////////////////////////////
	// Byte offsets in main space
	localparam logic [7:0] VOLATILE_LO      = 8'h60;
	localparam logic [7:0] TEMP_MSB_OFS     = 8'h60;
	localparam logic [7:0] TEMP_LSB_OFS     = 8'h61;
	localparam logic [7:0] TABLE_SELECT_OFS = 8'h7f;
	localparam logic [7:0] RES0_MANUAL_OFS  = 8'h82;
	localparam logic [7:0] RES1_MANUAL_OFS  = 8'h83;
	localparam logic [7:0] PROT_CFG_OFS     = 8'h89;
	localparam logic [7:0] MAIN_ADDR_OFS    = 8'h8c;

	////////////////////////////////////////////////////////////////////////////
	// Table numbers held in the table select byte
	localparam logic [7:0] TBL_EXTRA = 8'h00;
	localparam logic [7:0] TBL_CFG   = 8'h01;
	localparam logic [7:0] TBL_RES0  = 8'h02;
	localparam logic [7:0] TBL_RES1  = 8'h03;

	////////////////////////////////////////////////////////////////////////////
	// Bit positions in the protection configuration byte
	localparam int CFG_AUX_PROTECT_BIT  = 0;
	localparam int CFG_MAIN_PROTECT_BIT = 1;
	localparam int CFG_SINGLE_ADDR_BIT  = 2;
	localparam int CFG_ADDR_MEMORY_BIT  = 3;
	localparam int CFG_TEMP_INDEX_BIT   = 4;

	////////////////////////////////////////////////////////////////////////////
	// Temperature lookup range, whole degrees, and its table addresses
	localparam logic signed [7:0] TEMP_MIN  = -8'sd40;
	localparam logic signed [7:0] TEMP_MAX  = 8'sd102;
	localparam logic [7:0]        LUT_FIRST = 8'h80;
	localparam logic [7:0]        LUT_LAST  = 8'hc7;

	////////////////////////////////////////////////////////////////////////////
	// Reset and read-back values
	localparam logic [7:0] MEM_RESET_BYTE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ  = 8'hff;

	////////////////////////////////////////////////////////////////////////////
	// Serial slave states
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_PTR       = 4'h3,
		ST_PTR_ACK   = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RACK      = 4'h8
	} smap_state_t;

endpackage : smap_pkg

// File: dv/smap_host_model.sv
// Two-wire bus master model that drives the link of the memory access block
`timescale 1ns/1ps

module smap_host_model (
	// Clock
	input  wire logic i_clk,
	// Link
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Each SCL phase is ten clocks; SCL stands high between frames
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick

	// Also serves as a repeated start from SCL low
	task automatic start();
		o_sda_low = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(5);
		o_sda_low = 1'b1;
		tick(5);
		o_scl = 1'b0;
		tick(5);
	endtask : start

	task automatic stop();
		o_sda_low = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(5);
		o_sda_low = 1'b0;
		tick(10);
	endtask : stop

	// Data moves only while SCL is low; sampled late in SCL high to let the slave settle
	task automatic xbit(input logic b, output logic r);
		o_sda_low = ~b;
		tick(5);
		o_scl = 1'b1;
		tick(10);
		r = i_sda;
		o_scl = 1'b0;
		tick(5);
	endtask : xbit

	// Ninth bit m: 1 releases the line for the slave, 0 acks a read byte
	task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r[i]);
		end
		xbit(m, a);
	endtask : xbyte
endmodule : smap_host_model

// File: dv/tb_sensor_memory_access_protect.sv
// Self-checking bench of the memory access and write-protect block
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_sensor_memory_access_protect;
	localparam logic [7:0] MA = smap_pkg::MAIN_ADDR_DEFAULT;
	localparam logic [7:0] AX = smap_pkg::AUX_DEV_ADDR;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wp = 1'b0;
	logic        hiz = 1'b0;
	logic [15:0] temp = 16'h0000;
	logic        scl;
	logic        host_low;
	logic        o_sda;
	logic        oe_n;
	wire         sda_w = (oe_n ? 1'b1 : o_sda) & ~host_low;
	logic [7:0]  res0;
	logic [7:0]  res1;
	logic        res_hiz;
	int          error_cnt = 0;
	int          checks = 0;
	logic [31:0] seed = 32'h00009a7a;
	logic [7:0]  d1, d2, r, ad;
	logic        a;
	logic [7:0]  cn [8] = '{8'h80, 8'hd7, 8'hd8, 8'hd9, 8'h65, 8'h66, 8'h67, 8'h7f};

	always #4 clk = ~clk;

	smap_host_model u_host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low));

	smap_core u_dut (
		.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
		.o_sda_oe_n(oe_n), .i_write_protect_pin(wp), .i_resistor_disable_pin(hiz),
		.i_temp(temp), .o_res0_setting(res0), .o_res1_setting(res1), .o_res_hiz(res_hiz)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	function automatic logic [7:0] bitv(input int b);
		return 8'(1 << b);
	endfunction : bitv

	// Floor to whole degrees is implied by the signed upper byte
	function automatic logic [7:0] idx(input logic signed [7:0] t);
		if (t < smap_pkg::TEMP_MIN) return smap_pkg::LUT_FIRST;
		if (t > smap_pkg::TEMP_MAX) return smap_pkg::LUT_LAST;
		return smap_pkg::LUT_FIRST + 8'((int'(t) - int'(smap_pkg::TEMP_MIN)) / 2);
	endfunction : idx

	// Distinct per table, so a swapped resistor shows up
	function automatic logic [7:0] lut(input logic s, input logic [7:0] ad_i);
		return {ad_i[6:0], s} ^ 8'h3c;
	endfunction : lut

	////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic [7:0] dev, p, wd, input bit w, output logic [7:0] rd);
		logic [7:0] x;
		logic       k;
		u_host.start();
		u_host.xbyte(dev, 1'b1, x, k);
		`CHK(k, 1'b0)
		u_host.xbyte(p, 1'b1, x, k);
		`CHK(k, 1'b0)
		if (w) begin
			u_host.xbyte(wd, 1'b1, x, k);
			`CHK(k, 1'b0)
		end else begin
			u_host.start();
			u_host.xbyte(dev | 8'h01, 1'b1, x, k);
			`CHK(k, 1'b0)
			u_host.xbyte(8'hff, 1'b1, rd, k);
		end
		u_host.stop();
	endtask : acc

	task automatic wr(input logic [7:0] dev, p, wd);
		logic [7:0] x;
		acc(dev, p, wd, 1'b1, x);
	endtask : wr

	task automatic rd(input logic [7:0] dev, p, output logic [7:0] v);
		acc(dev, p, 8'h00, 1'b0, v);
	endtask : rd

	task automatic probe(input logic [7:0] dev, output logic k);
		logic [7:0] x;
		u_host.start();
		u_host.xbyte(dev, 1'b1, x, k);
		u_host.stop();
	endtask : probe

	// One burst per table keeps the run short
	task automatic lut_fill(input logic [7:0] t);
		logic [7:0] x;
		logic       k;
		wr(MA, smap_pkg::TABLE_SELECT_OFS, t);
		u_host.start();
		u_host.xbyte(MA, 1'b1, x, k);
		u_host.xbyte(smap_pkg::LUT_FIRST, 1'b1, x, k);
		for (int i = 0; i < 72; i++) begin
			u_host.xbyte(lut(t[0], smap_pkg::LUT_FIRST + 8'(i)), 1'b1, x, k);
		end
		u_host.stop();
	endtask : lut_fill

	task automatic complete_run();
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		temp = {rnd(), rnd()};
		wr(MA, 8'h7f, smap_pkg::TBL_CFG);
		rd(MA, 8'h8c, r);
		`CHK(r, MA)
		rd(MA, 8'h89, r);
		`CHK(r, 8'h00)
		d1 = rnd();
		wr(MA, 8'h62, d1);
		rd(MA, 8'h62, r);
		`CHK(r, d1)
		wr(MA, 8'h60, ~temp[15:8]);
		rd(MA, 8'h60, r);
		`CHK(r, temp[15:8])
		rd(MA, 8'h61, r);
		`CHK(r, temp[7:0])
		// Main protection needs both the pin and the bit
		d2 = ~d1;
		wr(MA, 8'h10, d1);
		wp = 1'b1;
		wr(MA, 8'h89, bitv(smap_pkg::CFG_MAIN_PROTECT_BIT));
		wr(MA, 8'h10, d2);
		rd(MA, 8'h10, r);
		`CHK(r, d1)
		wr(MA, 8'h63, d2);
		rd(MA, 8'h63, r);
		`CHK(r, d2)
		wp = 1'b0;
		wr(MA, 8'h10, d2);
		rd(MA, 8'h10, r);
		`CHK(r, d2)
		// Auxiliary protection ignores the pin
		wr(MA, 8'h89, 8'h00);
		wr(AX, 8'h05, d1);
		rd(AX, 8'h05, r);
		`CHK(r, d1)
		wr(MA, 8'h89, bitv(smap_pkg::CFG_AUX_PROTECT_BIT));
		wr(AX, 8'h05, d2);
		rd(AX, 8'h05, r);
		`CHK(r, d1)
		wr(MA, 8'h7f, smap_pkg::TBL_EXTRA);
		rd(MA, 8'h85, r);
		`CHK(r, d1)
		wr(MA, 8'h85, d2);
		rd(MA, 8'h85, r);
		`CHK(r, d1)
		wr(MA, 8'h7f, smap_pkg::TBL_CFG);
		wr(AX, 8'h89, 8'h00);
		rd(MA, 8'h89, r);
		`CHK(r, bitv(smap_pkg::CFG_AUX_PROTECT_BIT))
		rd(AX, 8'h89, r);
		`CHK(r, smap_pkg::UNMAPPED_READ)
		// Single address mode silences the auxiliary address
		wr(MA, 8'h89, bitv(smap_pkg::CFG_SINGLE_ADDR_BIT));
		probe(AX, a);
		`CHK(a, 1'b1)
		// Top bit clear keeps the coined address clear of both defaults
		ad = rnd() & 8'h7e;
		wr(MA, 8'h8c, ad);
		wr(MA, 8'h89, bitv(smap_pkg::CFG_ADDR_MEMORY_BIT));
		probe(MA, a);
		`CHK(a, 1'b1)
		rd(ad, 8'h89, r);
		`CHK(r, bitv(smap_pkg::CFG_ADDR_MEMORY_BIT))
		wr(ad, 8'h89, 8'h00);
		// Manual settings, then temperature indexing
		d1 = rnd();
		d2 = rnd();
		wr(MA, 8'h82, d1);
		wr(MA, 8'h83, d2);
		u_host.tick(5);
		`CHK(res0, d1)
		`CHK(res1, d2)
		lut_fill(smap_pkg::TBL_RES0);
		lut_fill(smap_pkg::TBL_RES1);
		wr(MA, 8'h7f, smap_pkg::TBL_CFG);
		wr(MA, 8'h89, bitv(smap_pkg::CFG_TEMP_INDEX_BIT));
		for (int i = 0; i < 28; i++) begin
			temp = {(i < 8) ? cn[i] : rnd(), rnd()};
			u_host.tick(5);
			`CHK(res0, lut(1'b0, idx(temp[15:8])))
			`CHK(res1, lut(1'b1, idx(temp[15:8])))
		end
		hiz = 1'b1;
		u_host.tick(5);
		`CHK(res_hiz, 1'b1)
		hiz = 1'b0;
		u_host.tick(5);
		`CHK(res_hiz, 1'b0)
		complete_run();
	end
endmodule : tb_sensor_memory_access_protect

// File: rtl/smap_core.sv
// Two-wire slave, paged memory, write protection and resistor setting logic
// Function
// R1 - Temperature picks table address 80h..C7h, clamped
// R2 - Eight-bit setting per resistor per address
// R3 - Temperature reads as signed byte plus fraction
// R4 - Disable pin high puts resistors high-impedance
// R5 - Index disabled: resistors use bytes 82h/83h
// R6 - Answer aux and main address, or main only
// R7 - Main address may come from byte 8Ch
// R8 - Upper bytes only via main, page by 7Fh
// R9 - Aux path cannot reach tables; aux is table
// R10 - Single address: table 00 extra, aux silent
// R11 - Programmable address allows 128 distinct devices
// R12 - Protect bits writable only through main address
// R13 - Main writes blocked when pin and bit high
// R14 - Aux writes blocked by aux protect bit only
// R15 - Table 00 follows aux protect bit only
// R16 - Bytes 60h..7Fh never write-protected
// R17 - Reserved volatile bytes act as scratch storage
// R18 - Protected or read-only bytes ignore writes
// R19 - Refused write still completes the transfer
`timescale 1ns/1ps

module smap_core (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Two-wire link
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe_n,
	// Pins
	input  wire logic        i_write_protect_pin,
	input  wire logic        i_resistor_disable_pin,
	// Temperature reading from the sensor, same clock
	input  wire logic [15:0] i_temp,
	// Resistor controls
	output logic [7:0]       o_res0_setting,
	output logic [7:0]       o_res1_setting,
	output logic             o_res_hiz
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		smap_pkg::smap_state_t st;
		logic [2:0]            cnt;
		logic [7:0]            sh;
		logic [7:0]            tx;
		logic [7:0]            ptr;
		logic                  is_aux;
		logic                  is_rd;
		logic                  sda_oe_n;
		logic                  scl_m;
		logic                  scl_s;
		logic                  scl_p;
		logic                  sda_m;
		logic                  sda_s;
		logic                  sda_p;
		logic                  wp_m;
		logic                  wp_s;
		logic                  resistor_disable_pin_m;
		logic                  resistor_disable_pin_s;
		logic [7:0]            res0;
		logic [7:0]            res1;
		logic                  hiz;
	} smap_core_t;

	smap_core_t s_q;
	smap_core_t s_d;

	// Nonvolatile tables kept in flops; reset stands in for factory defaults
	logic [7:0] main_lo_mem [128];
	logic [7:0] aux_mem     [128];
	logic [7:0] cfg_mem     [128];
	logic [7:0] lut0_mem    [128];
	logic [7:0] lut1_mem    [128];

	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic [7:0]  rx_byte;
	logic [7:0]  prot_cfg;
	logic        aux_protect;
	logic        main_protect;
	logic        single_addr;
	logic        addr_from_mem;
	logic        temp_index_en;
	logic [7:0]  main_addr;
	logic        hit_main;
	logic        hit_aux;
	logic [7:0]  tbl_sel;
	logic        main_locked;
	logic        wr_ok;
	logic        wr_try;
	logic        we_lo;
	logic        we_aux;
	logic        we_cfg;
	logic        we_l0;
	logic        we_l1;
	logic [7:0]  rd_ptr;
	logic [7:0]  rd_byte;
	logic [8:0]  temp_ofs;
	logic [6:0]  lut_idx;

	////////////////////////////////////////////////////////////////////////////
	// Link edges and conditions, taken from synchronised copies only

	assign scl_rise   = s_q.scl_s & ~s_q.scl_p;
	assign scl_fall   = ~s_q.scl_s & s_q.scl_p;
	assign start_cond = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
	assign stop_cond  = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
	assign rx_byte    = {s_q.sh[6:0], s_q.sda_s};

	////////////////////////////////////////////////////////////////////////////
	// Configuration bits

	assign prot_cfg      = cfg_mem[smap_pkg::PROT_CFG_OFS[6:0]];
	assign aux_protect   = prot_cfg[smap_pkg::CFG_AUX_PROTECT_BIT];
	assign main_protect  = prot_cfg[smap_pkg::CFG_MAIN_PROTECT_BIT];
	assign single_addr   = prot_cfg[smap_pkg::CFG_SINGLE_ADDR_BIT];
	assign addr_from_mem = prot_cfg[smap_pkg::CFG_ADDR_MEMORY_BIT];
	assign temp_index_en = prot_cfg[smap_pkg::CFG_TEMP_INDEX_BIT];
	assign tbl_sel       = main_lo_mem[smap_pkg::TABLE_SELECT_OFS[6:0]];

	// Any stored main address is honoured, so devices on one bus can differ
	assign main_addr = addr_from_mem ? cfg_mem[smap_pkg::MAIN_ADDR_OFS[6:0]]
		: smap_pkg::MAIN_ADDR_DEFAULT; // R7 R11
	assign hit_main  = rx_byte[7:1] == main_addr[7:1]; // R6
	assign hit_aux   = ~single_addr & (rx_byte[7:1] == smap_pkg::AUX_DEV_ADDR[7:1]); // R6 R10

	////////////////////////////////////////////////////////////////////////////
	// Write permission

	assign main_locked = s_q.wp_s & main_protect; // R13

	always_comb begin
		if (s_q.is_aux) begin
			wr_ok = ~aux_protect & ~s_q.ptr[7]; // R9 R14
		end else if (!s_q.ptr[7] && s_q.ptr >= smap_pkg::VOLATILE_LO) begin
			// Temperature bytes are read-only; the rest is open scratch
			wr_ok = (s_q.ptr != smap_pkg::TEMP_MSB_OFS)
				&& (s_q.ptr != smap_pkg::TEMP_LSB_OFS); // R16 R17 R18
		end else if (!s_q.ptr[7]) begin
			wr_ok = ~main_locked; // R13
		end else if (tbl_sel == smap_pkg::TBL_EXTRA) begin
			wr_ok = ~aux_protect; // R15
		end else if (tbl_sel == smap_pkg::TBL_CFG || tbl_sel == smap_pkg::TBL_RES0
			|| tbl_sel == smap_pkg::TBL_RES1) begin
			wr_ok = ~main_locked; // R12 R13
		end else begin
			wr_ok = 1'b0;
		end
	end

	// A refused write changes nothing; the byte is still acknowledged
	assign we_lo  = wr_try & wr_ok & ~s_q.is_aux & ~s_q.ptr[7]; // R18 R19
	assign we_aux = wr_try & wr_ok & (s_q.is_aux | (s_q.ptr[7]
		& (tbl_sel == smap_pkg::TBL_EXTRA))); // R9 R10
	assign we_cfg = wr_try & wr_ok & ~s_q.is_aux & s_q.ptr[7] & (tbl_sel == smap_pkg::TBL_CFG);
	assign we_l0  = wr_try & wr_ok & ~s_q.is_aux & s_q.ptr[7] & (tbl_sel == smap_pkg::TBL_RES0);
	assign we_l1  = wr_try & wr_ok & ~s_q.is_aux & s_q.ptr[7] & (tbl_sel == smap_pkg::TBL_RES1);

	////////////////////////////////////////////////////////////////////////////
	// Read path

	assign rd_ptr = (s_q.st == smap_pkg::ST_RACK) ? s_q.ptr + 8'h01 : s_q.ptr;

	always_comb begin
		if (s_q.is_aux) begin
			rd_byte = rd_ptr[7] ? smap_pkg::UNMAPPED_READ : aux_mem[rd_ptr[6:0]]; // R9
		end else if (rd_ptr == smap_pkg::TEMP_MSB_OFS) begin
			rd_byte = i_temp[15:8]; // R3
		end else if (rd_ptr == smap_pkg::TEMP_LSB_OFS) begin
			rd_byte = i_temp[7:0]; // R3
		end else if (!rd_ptr[7]) begin
			rd_byte = main_lo_mem[rd_ptr[6:0]];
		end else if (tbl_sel == smap_pkg::TBL_EXTRA) begin
			rd_byte = aux_mem[rd_ptr[6:0]]; // R8 R9 R10
		end else if (tbl_sel == smap_pkg::TBL_CFG) begin
			rd_byte = cfg_mem[rd_ptr[6:0]]; // R8
		end else if (tbl_sel == smap_pkg::TBL_RES0) begin
			rd_byte = lut0_mem[rd_ptr[6:0]]; // R8
		end else if (tbl_sel == smap_pkg::TBL_RES1) begin
			rd_byte = lut1_mem[rd_ptr[6:0]]; // R8
		end else begin
			rd_byte = smap_pkg::UNMAPPED_READ;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Temperature to table index, whole degrees, two degrees per entry

	assign temp_ofs = {i_temp[15], i_temp[15:8]}
		- {smap_pkg::TEMP_MIN[7], smap_pkg::TEMP_MIN};

	always_comb begin
		if ($signed(i_temp[15:8]) < smap_pkg::TEMP_MIN) begin
			lut_idx = smap_pkg::LUT_FIRST[6:0]; // R1
		end else if ($signed(i_temp[15:8]) > smap_pkg::TEMP_MAX) begin
			lut_idx = smap_pkg::LUT_LAST[6:0]; // R1
		end else begin
			lut_idx = temp_ofs[7:1]; // R1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d       = s_q;
		wr_try    = 1'b0;
		s_d.scl_m = i_scl;
		s_d.scl_s = s_q.scl_m;
		s_d.scl_p = s_q.scl_s;
		s_d.sda_m = i_sda;
		s_d.sda_s = s_q.sda_m;
		s_d.sda_p = s_q.sda_s;
		s_d.wp_m  = i_write_protect_pin;
		s_d.wp_s  = s_q.wp_m;
		s_d.resistor_disable_pin_m = i_resistor_disable_pin;
		s_d.resistor_disable_pin_s = s_q.resistor_disable_pin_m;
		if (start_cond) begin
			s_d.st       = smap_pkg::ST_ADDR;
			s_d.cnt      = 3'h0;
			s_d.sda_oe_n = 1'b1;
		end else if (stop_cond) begin
			s_d.st       = smap_pkg::ST_IDLE;
			s_d.sda_oe_n = 1'b1;
		end else if (scl_rise) begin
			case (s_q.st)
				smap_pkg::ST_ADDR, smap_pkg::ST_PTR, smap_pkg::ST_WDATA: begin
					s_d.sh  = rx_byte;
					s_d.cnt = s_q.cnt + 3'h1;
					if (s_q.cnt == 3'h7 && s_q.st == smap_pkg::ST_ADDR) begin
						// Main wins if both addresses happen to match
						if (hit_main || hit_aux) begin
							s_d.st     = smap_pkg::ST_ADDR_ACK; // R6 R10
							s_d.is_aux = ~hit_main;
							s_d.is_rd  = s_q.sda_s;
						end else begin
							s_d.st = smap_pkg::ST_IDLE;
						end
					end else if (s_q.cnt == 3'h7 && s_q.st == smap_pkg::ST_PTR) begin
						s_d.ptr = rx_byte;
						s_d.st  = smap_pkg::ST_PTR_ACK;
					end else if (s_q.cnt == 3'h7) begin
						wr_try  = 1'b1;
						s_d.ptr = s_q.ptr + 8'h01;
						s_d.st  = smap_pkg::ST_WDATA_ACK; // R19
					end
				end
				smap_pkg::ST_ADDR_ACK: begin
					s_d.cnt = 3'h0;
					s_d.st  = s_q.is_rd ? smap_pkg::ST_RDATA : smap_pkg::ST_PTR;
					s_d.tx  = rd_byte;
				end
				smap_pkg::ST_PTR_ACK, smap_pkg::ST_WDATA_ACK: begin
					s_d.cnt = 3'h0;
					s_d.st  = smap_pkg::ST_WDATA;
				end
				smap_pkg::ST_RDATA: begin
					s_d.cnt = s_q.cnt + 3'h1;
					if (s_q.cnt == 3'h7) begin
						s_d.st = smap_pkg::ST_RACK;
					end
				end
				smap_pkg::ST_RACK: begin
					if (s_q.sda_s) begin
						s_d.st = smap_pkg::ST_IDLE;
					end else begin
						s_d.ptr = rd_ptr;
						s_d.tx  = rd_byte;
						s_d.cnt = 3'h0;
						s_d.st  = smap_pkg::ST_RDATA;
					end
				end
				default: begin
					s_d.st = smap_pkg::ST_IDLE;
				end
			endcase
		end else if (scl_fall) begin
			// Output changes only while the clock is low, never mimicking a start
			case (s_q.st)
				smap_pkg::ST_ADDR_ACK, smap_pkg::ST_PTR_ACK, smap_pkg::ST_WDATA_ACK: begin
					s_d.sda_oe_n = 1'b0;
				end
				smap_pkg::ST_RDATA: begin
					s_d.sda_oe_n = s_q.tx[3'h7 - s_q.cnt];
				end
				default: begin
					s_d.sda_oe_n = 1'b1;
				end
			endcase
		end
		s_d.hiz  = s_q.resistor_disable_pin_s; // R4
		s_d.res0 = temp_index_en ? lut0_mem[lut_idx]
			: cfg_mem[smap_pkg::RES0_MANUAL_OFS[6:0]]; // R2 R5
		s_d.res1 = temp_index_en ? lut1_mem[lut_idx]
			: cfg_mem[smap_pkg::RES1_MANUAL_OFS[6:0]]; // R2 R5
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q          <= '0;
			s_q.st       <= smap_pkg::ST_IDLE;
			s_q.sda_oe_n <= 1'b1;
			s_q.scl_m    <= 1'b1;
			s_q.scl_s    <= 1'b1;
			s_q.scl_p    <= 1'b1;
			s_q.sda_m    <= 1'b1;
			s_q.sda_s    <= 1'b1;
			s_q.sda_p    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 128; i++) begin
				main_lo_mem[i] <= smap_pkg::MEM_RESET_BYTE;
				aux_mem[i]     <= smap_pkg::MEM_RESET_BYTE;
				cfg_mem[i]     <= smap_pkg::MEM_RESET_BYTE;
				lut0_mem[i]    <= smap_pkg::MEM_RESET_BYTE;
				lut1_mem[i]    <= smap_pkg::MEM_RESET_BYTE;
			end
			cfg_mem[smap_pkg::MAIN_ADDR_OFS[6:0]] <= smap_pkg::MAIN_ADDR_DEFAULT;
		end else begin
			if (we_lo) begin
				main_lo_mem[s_q.ptr[6:0]] <= rx_byte;
			end
			if (we_aux) begin
				aux_mem[s_q.ptr[6:0]] <= rx_byte;
			end
			if (we_cfg) begin
				cfg_mem[s_q.ptr[6:0]] <= rx_byte; // R12
			end
			if (we_l0) begin
				lut0_mem[s_q.ptr[6:0]] <= rx_byte;
			end
			if (we_l1) begin
				lut1_mem[s_q.ptr[6:0]] <= rx_byte;
			end
		end
	end

	assign o_sda          = 1'b0;
	assign o_sda_oe_n     = s_q.sda_oe_n;
	assign o_res0_setting = s_q.res0;
	assign o_res1_setting = s_q.res1;
	assign o_res_hiz      = s_q.hiz;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_hiz_follows_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R4
		i_resistor_disable_pin [*4] |-> o_res_hiz)
		else $error("resistors not high-impedance with disable pin high");

	a_manual_res0: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R5
		!temp_index_en |=> o_res0_setting == $past(cfg_mem[2]))
		else $error("manual resistor 0 setting not applied");

	a_lut_cold_clamp: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R1
		temp_index_en && $signed(i_temp[15:8]) < smap_pkg::TEMP_MIN
		|=> o_res0_setting == $past(lut0_mem[0]))
		else $error("cold temperature did not clamp to first entry");

	a_lut_hot_clamp: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R1
		temp_index_en && $signed(i_temp[15:8]) > smap_pkg::TEMP_MAX
		|=> o_res1_setting == $past(lut1_mem[71]))
		else $error("hot temperature did not clamp to last entry");

	a_main_locked_write: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R13
		wr_try && !s_q.is_aux && s_q.ptr < 8'h60 && s_q.wp_s && main_protect
		|=> main_lo_mem[$past(s_q.ptr[6:0])] == $past(main_lo_mem[s_q.ptr[6:0]]))
		else $error("locked main byte changed");

	a_aux_locked_write: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R14
		wr_try && s_q.is_aux && aux_protect
		|=> aux_mem[$past(s_q.ptr[6:0])] == $past(aux_mem[s_q.ptr[6:0]]))
		else $error("protected auxiliary byte changed");

	a_extra_table_lock: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R15
		wr_try && !s_q.is_aux && s_q.ptr[7] && tbl_sel == 8'h00 && aux_protect
		|=> aux_mem[$past(s_q.ptr[6:0])] == $past(aux_mem[s_q.ptr[6:0]]))
		else $error("protected table 00 byte changed");

	a_scratch_open: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R16
		wr_try && !s_q.is_aux && s_q.ptr > 8'h61 && s_q.ptr < 8'h80
		|=> main_lo_mem[$past(s_q.ptr[6:0])] == $past(rx_byte))
		else $error("volatile byte refused a write");

	a_single_addr_silent: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R10
		s_q.st == smap_pkg::ST_ADDR_ACK && single_addr |-> !s_q.is_aux)
		else $error("auxiliary address answered in single address mode");

	a_ack_driven: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R19
		s_q.st == smap_pkg::ST_WDATA_ACK && scl_fall |=> !o_sda_oe_n)
		else $error("write byte not acknowledged");

	c_main_write: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		we_lo && !main_locked);
	c_aux_read: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		s_q.st == smap_pkg::ST_RDATA && s_q.is_aux);
	c_refused_write: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_try && !wr_ok);
	c_indexed: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		temp_index_en && lut_idx == 7'h47);

endmodule : smap_core
